// ==== logic/cfs_filter.sv ====
// Purpose: single acceptance filter with standard identifier register
// Assumes: frame and mask inputs synchronous to clock_i
// Notes: decision appears one cycle after the frame strobe
`timescale 1ns/1ps
module cfs_filter (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire cfs_pkg::cfs_frame_t frame_i,
    input wire cfs_pkg::cfs_mask_t mask_i,
    output logic accept_o,
    output logic reject_o,
    output logic error_o
);
    import cfs_pkg::*;

    // ------------------------------------------------------------
    // limits of this filter
    // ------------------------------------------------------------
    // stored pattern clears on reset so a fresh filter is defined
    // mask and type match are levels, hold them steady across a frame
    // only bits 17:16 of an extended identifier are compared here
    // bits 4 and 2 are tied low in storage and on read
    // a disabled filter stays silent and keeps its status
    // frames may come every cycle, decisions never overlap

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] id_q;
    logic en_q;
    cfs_result_t res_q;
    cfs_result_t res_d;
    logic [7:0] cnt_q;
    logic [15:0] rdata_q;
    logic accept_q;
    logic reject_q;
    logic error_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // exact byte-address match for one register place
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] place);
        return addr == place;
    endfunction : addr_hit

    wire logic hit_id = addr_hit(addr_i, CFS_ADDR_ID);
    wire logic hit_ctrl = addr_hit(addr_i, CFS_ADDR_CTRL);
    wire logic hit_stat = addr_hit(addr_i, CFS_ADDR_STAT);
    wire logic wr_id = wr_i && hit_id;
    wire logic wr_ctrl = wr_i && hit_ctrl;

    // stored fields
    wire logic [10:0] sid_f = id_q[CFS_SID_MSB:CFS_SID_LSB];
    wire logic [1:0] eid_f = id_q[CFS_EID_MSB:CFS_EID_LSB];
    wire logic fts_f = id_q[CFS_FTS_BIT];

    // ------------------------------------------------------------
    // comparison
    // ------------------------------------------------------------
    // per-bit agreement, a masked-off bit always agrees
    logic [10:0] sid_bit_ok;
    logic [1:0] eid_bit_ok;
    for (genvar g = 0; g < 11; g++) begin : g_sid_bit
        assign sid_bit_ok[g] = !mask_i.sid_mask[g] || (sid_f[g] == frame_i.std_identifier_bits[g]);
    end
    for (genvar g = 0; g < 2; g++) begin : g_eid_bit
        assign eid_bit_ok[g] = !mask_i.eid_mask[g] || (eid_f[g] == frame_i.extended_identifier_bits[16 + g]);
    end
    // masked standard bits must agree
    wire logic sid_ok = &sid_bit_ok;
    // extended bits 17:16 only meaningful on extended frames
    wire logic eid_ok = !frame_i.extended || (&eid_bit_ok);
    // frame type check only when the mask asks for it
    wire logic type_ok = !mask_i.type_match
        || (fts_f == frame_i.extended);
    wire logic id_ok = sid_ok && eid_ok && type_ok;

    // decision: errors first, then filter comparison
    always_comb begin
        res_d = CFS_RES_NONE;
        if (frame_i.valid && en_q) begin
            if (!frame_i.crc_ok) begin
                res_d = CFS_RES_ERROR;
            end else if (id_ok) begin
                res_d = CFS_RES_HIT;
            end else begin
                res_d = CFS_RES_MISS;
            end
        end
    end

    // read data select, unmapped reads as zero
    wire logic [15:0] stat_w = {cnt_q, 6'h00, (res_q == CFS_RES_ERROR),
        (res_q == CFS_RES_HIT)};
    wire logic [15:0] rsel = hit_id ? (id_q & CFS_ID_WMASK)
        : hit_ctrl ? {15'h0000, en_q}
        : hit_stat ? stat_w
        : 16'h0000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // software-written identifier and control
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            id_q <= CFS_ID_RESET;
            en_q <= CFS_CTRL_RESET;
        end else begin
            if (wr_id) begin
                id_q <= wdata_i & CFS_ID_WMASK;
            end
            if (wr_ctrl) begin
                en_q <= wdata_i[CFS_CTRL_EN_BIT];
            end
        end
    end

    // last decision and accepted frame count
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            res_q <= CFS_RES_NONE;
            cnt_q <= CFS_CNT_RESET;
        end else if (res_d != CFS_RES_NONE) begin
            res_q <= res_d;
            if (res_d == CFS_RES_HIT) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_q <= 16'h0000;
            accept_q <= 1'b0;
            reject_q <= 1'b0;
            error_q <= 1'b0;
        end else begin
            rdata_q <= rd_i ? rsel : 16'h0000;
            accept_q <= (res_d == CFS_RES_HIT);
            reject_q <= (res_d == CFS_RES_MISS);
            error_q <= (res_d == CFS_RES_ERROR);
        end
    end

    assign rdata_o = rdata_q;
    assign accept_o = accept_q;
    assign reject_o = reject_q;
    assign error_o = error_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ext_only: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && mask_i.type_match && id_q[CFS_FTS_BIT] && !frame_i.extended
        |=> !accept_o)
        else $error("extended-only filter accepted a standard frame");

    a_std_only: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && mask_i.type_match && !id_q[CFS_FTS_BIT] && frame_i.extended
        |=> !accept_o)
        else $error("standard-only filter accepted an extended frame");

    a_type_ignored: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && en_q && frame_i.crc_ok && !mask_i.type_match
        && sid_ok && eid_ok |=> accept_o)
        else $error("frame type not ignored with type match clear");

    a_select_bit: assert property (@(posedge clock_i) disable iff (srst_i)
        wr_id ##1 (rd_i && hit_id && !wr_i)
        |=> rdata_o[CFS_FTS_BIT] == $past(wdata_i[CFS_FTS_BIT], 2))
        else $error("frame type select did not read back");

    a_unused_zero: assert property (@(posedge clock_i) disable iff (srst_i)
        $past(rd_i && hit_id) |-> (rdata_o[4] == 1'b0 && rdata_o[2] == 1'b0))
        else $error("unused identifier bits read nonzero");

    a_sid_match: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && (((sid_f ^ frame_i.std_identifier_bits) & mask_i.sid_mask) != 11'h000)
        |=> !accept_o)
        else $error("masked standard identifier mismatch accepted");

    a_error_first: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && en_q && !frame_i.crc_ok |=> error_o && !accept_o && !reject_o)
        else $error("errored frame reached the comparison");

    a_one_result: assert property (@(posedge clock_i) disable iff (srst_i)
        $onehot0({accept_o, reject_o, error_o}))
        else $error("more than one decision at once");

    // ------------------------------------------------------------
    // register assertions
    // ------------------------------------------------------------
    // stored fields follow the write, unused places never do
    a_select_write: assert property (@(posedge clock_i) disable iff (srst_i)
        wr_id |=> id_q[CFS_FTS_BIT] == $past(wdata_i[CFS_FTS_BIT]))
        else $error("frame type select not stored on write");

    a_sid_store: assert property (@(posedge clock_i) disable iff (srst_i)
        wr_id |=> id_q[CFS_SID_MSB:CFS_SID_LSB] == $past(wdata_i[CFS_SID_MSB:CFS_SID_LSB]))
        else $error("standard identifier bits not stored on write");

    a_eid_store: assert property (@(posedge clock_i) disable iff (srst_i)
        wr_id |=> id_q[CFS_EID_MSB:CFS_EID_LSB] == $past(wdata_i[CFS_EID_MSB:CFS_EID_LSB]))
        else $error("extended identifier bits not stored on write");

    a_unused_stored: assert property (@(posedge clock_i) disable iff (srst_i)
        wr_id |=> (id_q[4] == 1'b0 && id_q[2] == 1'b0))
        else $error("write reached an unused identifier bit");

    // the pattern only moves on a write to its own place
    a_id_hold: assert property (@(posedge clock_i) disable iff (srst_i)
        !wr_id |=> $stable(id_q))
        else $error("identifier register changed without a write");

    // a write followed at once by a read returns the new pattern
    a_sid_read: assert property (@(posedge clock_i) disable iff (srst_i)
        wr_id ##1 (rd_i && hit_id && !wr_i)
        |=> rdata_o[CFS_SID_MSB:CFS_SID_LSB] == $past(wdata_i[CFS_SID_MSB:CFS_SID_LSB], 2))
        else $error("standard identifier bits did not read back");

    a_eid_read: assert property (@(posedge clock_i) disable iff (srst_i)
        wr_id ##1 (rd_i && hit_id && !wr_i)
        |=> rdata_o[CFS_EID_MSB:CFS_EID_LSB] == $past(wdata_i[CFS_EID_MSB:CFS_EID_LSB], 2))
        else $error("extended identifier bits did not read back");

    // read data stand only in the cycle after the read strobe
    a_read_idle: assert property (@(posedge clock_i) disable iff (srst_i)
        !rd_i |=> rdata_o == 16'h0000)
        else $error("read data present without a read strobe");

    // ------------------------------------------------------------
    // decision assertions
    // ------------------------------------------------------------
    // a matching frame of the selected type is taken
    a_ext_accept: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && en_q && frame_i.crc_ok && mask_i.type_match && id_q[CFS_FTS_BIT]
        && frame_i.extended && (((sid_f ^ frame_i.std_identifier_bits) & mask_i.sid_mask) == 11'h000)
        && (((eid_f ^ frame_i.extended_identifier_bits[17:16]) & mask_i.eid_mask) == 2'h0) |=> accept_o)
        else $error("extended-only filter refused a matching extended frame");

    a_std_accept: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && en_q && frame_i.crc_ok && mask_i.type_match && !id_q[CFS_FTS_BIT]
        && !frame_i.extended && (((sid_f ^ frame_i.std_identifier_bits) & mask_i.sid_mask) == 11'h000)
        |=> accept_o)
        else $error("standard-only filter refused a matching standard frame");

    // masked-off bits never block acceptance
    a_mask_clear: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && en_q && frame_i.crc_ok && !mask_i.type_match
        && mask_i.sid_mask == 11'h000 && mask_i.eid_mask == 2'h0 |=> accept_o)
        else $error("fully masked filter refused a frame");

    // a masked mismatch is refused
    a_sid_reject: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && en_q && frame_i.crc_ok
        && (((sid_f ^ frame_i.std_identifier_bits) & mask_i.sid_mask) != 11'h000) |=> reject_o)
        else $error("masked standard identifier mismatch not refused");

    a_eid_reject: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && en_q && frame_i.crc_ok && frame_i.extended
        && (((eid_f ^ frame_i.extended_identifier_bits[17:16]) & mask_i.eid_mask) != 2'h0) |=> reject_o)
        else $error("masked extended identifier mismatch not refused");

    // every output pulse traces back to a frame one cycle earlier
    a_accept_cause: assert property (@(posedge clock_i) disable iff (srst_i)
        accept_o |-> $past(frame_i.valid && en_q && frame_i.crc_ok))
        else $error("accept without an error-free enabled frame");

    a_reject_cause: assert property (@(posedge clock_i) disable iff (srst_i)
        reject_o |-> $past(frame_i.valid && en_q && frame_i.crc_ok))
        else $error("reject without an error-free enabled frame");

    a_error_cause: assert property (@(posedge clock_i) disable iff (srst_i)
        error_o |-> $past(frame_i.valid && en_q && !frame_i.crc_ok))
        else $error("error without an errored enabled frame");

    // an enabled frame always gets a decision, a disabled filter none
    a_one_decision: assert property (@(posedge clock_i) disable iff (srst_i)
        frame_i.valid && en_q |=> (accept_o || reject_o || error_o))
        else $error("enabled frame got no decision");

    a_disabled_quiet: assert property (@(posedge clock_i) disable iff (srst_i)
        !en_q |=> (!accept_o && !reject_o && !error_o))
        else $error("disabled filter gave a decision");

    // accepted count steps once per accepted frame
    a_count_step: assert property (@(posedge clock_i) disable iff (srst_i)
        accept_o |-> cnt_q == $past(cnt_q) + 8'h01)
        else $error("accepted count did not step");

    a_count_hold: assert property (@(posedge clock_i) disable iff (srst_i)
        !accept_o |-> $stable(cnt_q))
        else $error("accepted count moved without an accept");

endmodule : cfs_filter

// ==== logic/cfs_pkg.sv ====
// Purpose: constants and carriers for one acceptance filter identifier check
// Assumes: 16-bit register port, registers on word offsets
// Notes: all offsets, fields and reset values live here
package cfs_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CFS_ADDR_ID = 8'h00;
    localparam logic [7:0] CFS_ADDR_CTRL = 8'h04;
    localparam logic [7:0] CFS_ADDR_STAT = 8'h08;

    // ------------------------------------------------------------
    // identifier register fields
    // ------------------------------------------------------------
    localparam int CFS_SID_LSB = 5;
    localparam int CFS_SID_MSB = 15;
    localparam int CFS_FTS_BIT = 3;
    localparam int CFS_EID_LSB = 0;
    localparam int CFS_EID_MSB = 1;
    localparam logic [15:0] CFS_ID_WMASK = 16'hFFEB;
    localparam logic [15:0] CFS_ID_RESET = 16'h0000;

    // ------------------------------------------------------------
    // control and status fields
    // ------------------------------------------------------------
    localparam int CFS_CTRL_EN_BIT = 0;
    localparam logic CFS_CTRL_RESET = 1'b0;
    localparam int CFS_STAT_HIT_BIT = 0;
    localparam int CFS_STAT_ERR_BIT = 1;
    localparam int CFS_STAT_CNT_LSB = 8;
    localparam logic [7:0] CFS_CNT_RESET = 8'h00;

    // received frame as handed over by the protocol engine
    typedef struct packed {
        logic valid;
        logic extended;
        logic crc_ok;
        logic [10:0] std_identifier_bits;
        logic [17:0] extended_identifier_bits;
    } cfs_frame_t;

    // mask bits supplied by the associated mask register
    typedef struct packed {
        logic type_match;
        logic [10:0] sid_mask;
        logic [1:0] eid_mask;
    } cfs_mask_t;

    // filter decision for a frame
    typedef enum logic [1:0] {
        CFS_RES_NONE,
        CFS_RES_HIT,
        CFS_RES_MISS,
        CFS_RES_ERROR
    } cfs_result_t;

endpackage : cfs_pkg

// ==== verif/cfs_node_model.sv ====
// Purpose: remote node model handing received frames to the filter
// Assumes: one frame per call, valid for one cycle
// Notes: idle fields show inverted values so stale data never passes
`timescale 1ns/1ps
module cfs_node_model (
    input wire logic clock_i,
    output cfs_pkg::cfs_frame_t frame_o
);
    import cfs_pkg::*;
    initial frame_o = '0;
    // one frame pulse, then inverted idle pattern
    task automatic send(input logic ext, input logic ok, input logic [10:0] std_identifier_bits,
            input logic [17:0] extended_identifier_bits);
        @(posedge clock_i);
        frame_o <= {1'b1, ext, ok, std_identifier_bits, extended_identifier_bits};
        @(posedge clock_i);
        frame_o <= {1'b0, ~ext, ~ok, ~std_identifier_bits, ~extended_identifier_bits};
    endtask : send
endmodule : cfs_node_model

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the acceptance filter
// Assumes: register port with read data one cycle after the strobe
// Notes: decisions sampled one cycle after the frame pulse
`timescale 1ns/1ps
module tb;
    import cfs_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    cfs_frame_t frame_i;
    cfs_mask_t mask_i = '0;
    logic accept_o, reject_o, error_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    // clock and instances
    always #4 clock_i = ~clock_i;
    cfs_filter cfs_filter_i (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .frame_i(frame_i), .mask_i(mask_i), .accept_o(accept_o),
        .reject_o(reject_o), .error_o(error_o));
    cfs_node_model cfs_node_model_i (.clock_i(clock_i), .frame_o(frame_i));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // hang guard
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk("rdata", rdata_o, exp);
    endtask : rdchk
    task automatic fr(input logic x, input logic ok, input logic [10:0] s,
            input logic [17:0] e, input logic [2:0] exp);
        cfs_node_model_i.send(x, ok, s, e);
        #1 chk("decision", {13'h0000, accept_o, reject_o, error_o}, {13'h0000, exp});
    endtask : fr
    // write then read with no gap: new pattern, unused bits dropped
    task automatic t_back;
        @(posedge clock_i);
        addr_i <= CFS_ADDR_ID;
        wdata_i <= 16'hA5DE;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk("rdata", rdata_o, 16'hA5CA);
    endtask : t_back
    // register access, unused bits, unmapped place
    task automatic t_regs;
        rdchk(CFS_ADDR_ID, 16'h0000);
        rdchk(CFS_ADDR_CTRL, 16'h0000);
        rdchk(CFS_ADDR_STAT, 16'h0000);
        wr(CFS_ADDR_ID, 16'hFFFF);
        rdchk(CFS_ADDR_ID, 16'hFFEB);
        wr(CFS_ADDR_ID, 16'h0014);
        rdchk(CFS_ADDR_ID, 16'h0000);
        rdchk(8'h0C, 16'h0000);
        t_back();
    endtask : t_regs
    // frame type select under type match control
    task automatic t_type;
        rdchk(CFS_ADDR_CTRL, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            wr(CFS_ADDR_ID, {12'h000, i[1], 3'h0});
            mask_i <= '{i[0], 11'h000, 2'h0};
            fr(i[2], 1'b1, 11'h7FF, 18'h3FFFF, (!i[0] || i[1] == i[2]) ? 3'h4 : 3'h2);
        end
    endtask : t_type
    // identifier bits under full mask
    task automatic t_ident;
        wr(CFS_ADDR_ID, 16'hB462);
        mask_i <= '{1'b0, 11'h7FF, 2'h3};
        fr(1'b0, 1'b1, 11'h5A3, 18'h00000, 3'h4);
        fr(1'b0, 1'b1, 11'h5A2, 18'h00000, 3'h2);
        fr(1'b1, 1'b1, 11'h5A3, 18'h20000, 3'h4);
        fr(1'b1, 1'b1, 11'h5A3, 18'h10000, 3'h2);
        fr(1'b1, 1'b0, 11'h5A3, 18'h20000, 3'h1);
        rdchk(CFS_ADDR_STAT, 16'h0802);
    endtask : t_ident
    initial begin
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        t_regs();
        fr(1'b0, 1'b1, 11'h000, 18'h00000, 3'h0);
        wr(CFS_ADDR_CTRL, 16'h0001);
        t_type();
        t_ident();
        give_verdict();
    end
endmodule : tb
